// File: include/cil_pkg.sv
// constants, types and shared functions of the card isolation logic
package cil_pkg;

  // ****************************************
  // port addresses (12-bit decode)
  // ****************************************
  localparam logic [11:0] CIL_ADDR_PORT  = 12'h0279;
  localparam logic [11:0] CIL_WDATA_PORT = 12'h0a79;
  localparam logic [1:0]  CIL_RDP_HI     = 2'h0;
  localparam logic [1:0]  CIL_RDP_LO     = 2'h3;

  // ****************************************
  // configuration register indices
  // ****************************************
  localparam logic [7:0] CIL_REG_SET_RD   = 8'h00;
  localparam logic [7:0] CIL_REG_ISOLATE  = 8'h01;
  localparam logic [7:0] CIL_REG_CTRL     = 8'h02;
  localparam logic [7:0] CIL_REG_WAKE     = 8'h03;
  localparam logic [7:0] CIL_REG_HANDLE   = 8'h06;
  localparam logic [7:0] CIL_REG_LDN      = 8'h07;
  localparam int         CIL_CTRL_RST_LD  = 0;
  localparam int         CIL_CTRL_WFK     = 1;
  localparam int         CIL_CTRL_CLR_HDL = 2;
  localparam logic [7:0] CIL_LDN_VALUE    = 8'h00;

  // ****************************************
  // isolation and key constants
  // ****************************************
  localparam logic [7:0] CIL_ISO_FIRST    = 8'h55;
  localparam logic [7:0] CIL_ISO_SECOND   = 8'haa;
  localparam logic [1:0] CIL_SENSE_FIRST  = 2'h1;
  localparam logic [1:0] CIL_SENSE_SECOND = 2'h2;
  localparam logic [6:0] CIL_ID_BITS      = 7'h48;
  localparam int         CIL_ID_WORD      = 32;
  localparam logic [5:0] CIL_KEY_LEN      = 6'h20;
  localparam logic [7:0] CIL_LFSR_SEED    = 8'h6a;
  localparam logic [7:0] CIL_HANDLE_NONE  = 8'h00;

  typedef enum logic [1:0] {
    CIL_WAIT_KEY = 2'h0,
    CIL_SLEEP    = 2'h1,
    CIL_ISOLATE  = 2'h3,
    CIL_CONFIG   = 2'h2
  } cil_state_e;

  // one step of the key / checksum shift register
  function automatic logic [7:0] cil_lfsr_next(logic [7:0] v, logic b);
    cil_lfsr_next = {v[1] ^ v[0] ^ b, v[7:1]};
  endfunction

endpackage

// File: core/cil_key_detect.sv
// initiation key detector on the address port
`timescale 1ns/1ps
module cil_key_detect
  import cil_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       acc,
  input  wire logic       acc_wr,
  input  wire logic [7:0] data,
  output logic            key_ok
);

  typedef struct packed {
    logic [7:0] lfsr;
    logic [5:0] cnt;
    logic       hit;
  } cil_key_s;

  cil_key_s q;
  cil_key_s d;

  // ****************************************
  // sequence check
  // ****************************************
  always_comb
  begin
    d     = q;
    d.hit = 1'b0;
    if (acc)
    begin
      if (acc_wr && data == q.lfsr)
      begin
        if (q.cnt == CIL_KEY_LEN - 6'h1)
        begin
          d.hit  = 1'b1;
          d.lfsr = CIL_LFSR_SEED;
          d.cnt  = 6'h0;
        end
        else
        begin
          d.lfsr = cil_lfsr_next(q.lfsr, 1'b0);
          d.cnt  = q.cnt + 6'h1;
        end
      end
      // a stray access restarts; a seed byte counts as a fresh start
      else if (acc_wr && data == CIL_LFSR_SEED)
      begin
        d.lfsr = cil_lfsr_next(CIL_LFSR_SEED, 1'b0);
        d.cnt  = 6'h1;
      end
      else
      begin
        d.lfsr = CIL_LFSR_SEED;
        d.cnt  = 6'h0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q.lfsr <= CIL_LFSR_SEED;
      q.cnt  <= 6'h0;
      q.hit  <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign key_ok = q.hit;

  a_key_restart: assert property (@(posedge clk) disable iff (!rst_n)
    acc && !acc_wr |=> q.cnt == 6'h0 && !q.hit)
    else $error("key sequence not restarted by a read");

endmodule

// File: core/cil_serial_id.sv
// 72-bit serial identifier with checksum generated on chip
`timescale 1ns/1ps
module cil_serial_id
  import cil_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID  = 32'h1234_5678, // arbitrary value
  parameter logic [31:0] SERIAL_NUM = 32'h0000_0001  // arbitrary value
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] idx,
  output logic            id_bit
);

  // checksum walks the first 64 bits in shift order
  function automatic logic [7:0] cil_id_cksum(logic [2*CIL_ID_WORD-1:0] v);
    logic [7:0] cs;
    cs = CIL_LFSR_SEED;
    for (int i = 0; i < 2 * CIL_ID_WORD; i++)
      cs = cil_lfsr_next(cs, v[i]);
    cil_id_cksum = cs;
  endfunction

  // bit 0 is vendor byte 0 bit 0, shifted out first
  localparam logic [71:0] CIL_ID = {cil_id_cksum({SERIAL_NUM, VENDOR_ID}), SERIAL_NUM, VENDOR_ID};

  typedef struct packed {
    logic bit_v;
  } cil_id_s;

  cil_id_s q;
  cil_id_s d;

  always_comb
  begin
    d       = q;
    d.bit_v = (idx < CIL_ID_BITS) ? CIL_ID[idx] : 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q.bit_v <= 1'b0;
    else
      q <= d;
  end

  assign id_bit = q.bit_v;

endmodule

// File: core/cil_core.sv
// plug-and-play isolation front end: key, isolation, card states
`timescale 1ns/1ps
module cil_core
  import cil_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] sa,
  input  wire logic        aen,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic [7:0]  sd_in,
  output logic      [7:0]  sd_out,
  output logic             sd_oe,
  output logic             cfg_ports_en,
  output logic      [1:0]  card_state,
  output logic      [7:0]  card_handle,
  output logic             ld_reset,
  output logic             res_ptr_rewind
);

  typedef struct packed {
    logic [11:0] sa_m;
    logic [11:0] sa_s;
    logic [7:0]  sd_m;
    logic [7:0]  sd_s;
    logic [2:0]  ctl_m;
    logic [2:0]  ctl_s;
    logic [2:0]  ctl_p;
    cil_state_e  st;
    logic [7:0]  addr;
    logic [7:0]  rdp;
    logic [7:0]  handle;
    logic [6:0]  idx;
    logic        second;
    logic        sense1;
    logic        rd_iso;
    logic [1:0]  smp;
    logic [7:0]  sd_out;
    logic        sd_oe;
    logic        ld_reset;
    logic        rewind;
    logic        ports_en;
  } cil_core_s;

  cil_core_s q;
  cil_core_s d;

  logic       id_bit;
  logic       key_ok;
  logic       rd_start;
  logic       rd_end;
  logic       wr_end;
  logic       ior_low;
  logic       at_addr;
  logic       at_wdata;
  logic       at_rdp;
  logic       match;
  logic       key_acc;

  // ****************************************
  // cycle decode on synchronised pins
  // ****************************************
  // ctl bits: 2 aen, 1 ior_n, 0 iow_n; aen high marks a dma cycle
  assign ior_low  = !q.ctl_s[2] && !q.ctl_s[1];
  assign rd_start = ior_low && q.ctl_p[1];
  assign rd_end   = !q.ctl_s[2] && q.ctl_s[1] && !q.ctl_p[1];
  assign wr_end   = !q.ctl_s[2] && q.ctl_s[0] && !q.ctl_p[0];
  assign at_addr  = q.sa_s == CIL_ADDR_PORT;
  assign at_wdata = q.sa_s == CIL_WDATA_PORT;
  assign at_rdp   = q.sa_s == {CIL_RDP_HI, q.rdp, CIL_RDP_LO};
  assign match    = q.smp == (q.second ? CIL_SENSE_SECOND : CIL_SENSE_FIRST);
  assign key_acc  = at_addr && (rd_end || wr_end);

  cil_key_detect u_key
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .acc    (key_acc),
    .acc_wr (wr_end),
    .data   (q.sd_s),
    .key_ok (key_ok)
  );

  cil_serial_id u_id
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .idx    (q.idx),
    .id_bit (id_bit)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d          = q;
    d.sa_m     = sa;
    d.sa_s     = q.sa_m;
    d.sd_m     = sd_in;
    d.sd_s     = q.sd_m;
    d.ctl_m    = {aen, ior_n, iow_n};
    d.ctl_s    = q.ctl_m;
    d.ctl_p    = q.ctl_s;
    d.ld_reset = 1'b0;
    d.rewind   = 1'b0;

    // key is only looked for while the ports are closed
    if (q.st == CIL_WAIT_KEY && key_ok)
      d.st = CIL_SLEEP;

    // read start: choose what to put on the bus
    if (rd_start && at_rdp && q.st != CIL_WAIT_KEY)
    begin
      case (q.addr)
        CIL_REG_ISOLATE:
        begin
          if (q.st == CIL_ISOLATE && q.handle == CIL_HANDLE_NONE && q.idx < CIL_ID_BITS)
          begin
            d.rd_iso = 1'b1;
            d.sd_oe  = id_bit;
            d.sd_out = q.second ? CIL_ISO_SECOND : CIL_ISO_FIRST;
          end
        end
        CIL_REG_HANDLE:
        begin
          d.sd_oe  = q.handle != CIL_HANDLE_NONE;
          d.sd_out = q.handle;
        end
        CIL_REG_LDN:
        begin
          d.sd_oe  = q.handle != CIL_HANDLE_NONE;
          d.sd_out = CIL_LDN_VALUE;
        end
        default:
        begin
          d.sd_oe = 1'b0;
        end
      endcase
    end

    // floating cards watch the low two lines for the whole strobe
    if (q.rd_iso && ior_low)
      d.smp = q.sd_s[1:0];

    // read end: release bus, judge the pair
    if (rd_end)
    begin
      d.sd_oe = 1'b0;
      if (q.rd_iso)
      begin
        d.rd_iso = 1'b0;
        if (!q.second)
        begin
          d.sense1 = match;
          d.second = 1'b1;
        end
        else
        begin
          d.second = 1'b0;
          if (!id_bit && q.sense1 && match)
            d.st = CIL_SLEEP;
          else
            d.idx = q.idx + 7'h1;
        end
      end
    end

    // writes through the address and data ports
    if (wr_end && q.st != CIL_WAIT_KEY)
    begin
      if (at_addr)
        d.addr = q.sd_s;
      else if (at_wdata)
      begin
        case (q.addr)
          CIL_REG_SET_RD:
          begin
            d.rdp = q.sd_s;
          end
          CIL_REG_CTRL:
          begin
            d.ld_reset = q.sd_s[CIL_CTRL_RST_LD];
            if (q.sd_s[CIL_CTRL_CLR_HDL])
              d.handle = CIL_HANDLE_NONE;
            if (q.sd_s[CIL_CTRL_WFK])
              d.st = CIL_WAIT_KEY;
          end
          CIL_REG_WAKE:
          begin
            if (q.sd_s == q.handle)
            begin
              if (q.st == CIL_SLEEP)
              begin
                d.st     = (q.sd_s == CIL_HANDLE_NONE) ? CIL_ISOLATE : CIL_CONFIG;
                d.rewind = 1'b1;
                d.idx    = 7'h0;
                d.second = 1'b0;
                d.sense1 = 1'b0;
              end
            end
            else if (q.st == CIL_ISOLATE || q.st == CIL_CONFIG)
              d.st = CIL_SLEEP;
          end
          CIL_REG_HANDLE:
          begin
            // in isolation only the card that survived all 72 pairs takes a handle; a card in config takes any new handle
            if (q.st == CIL_ISOLATE && q.idx == CIL_ID_BITS)
            begin
              d.handle = q.sd_s;
              d.st     = CIL_CONFIG;
            end
            else if (q.st == CIL_CONFIG)
              d.handle = q.sd_s;
          end
          default:
          begin
            d.ld_reset = 1'b0;
          end
        endcase
      end
    end

    // registered beside the state so the port flag leaves a flop
    d.ports_en = d.st != CIL_WAIT_KEY;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q.sa_m     <= 12'h000;
      q.sa_s     <= 12'h000;
      q.sd_m     <= 8'h00;
      q.sd_s     <= 8'h00;
      q.ctl_m    <= 3'h7;
      q.ctl_s    <= 3'h7;
      q.ctl_p    <= 3'h7;
      q.st       <= CIL_WAIT_KEY;
      q.addr     <= CIL_REG_SET_RD;
      q.rdp      <= 8'h00;
      q.handle   <= CIL_HANDLE_NONE;
      q.idx      <= 7'h0;
      q.second   <= 1'b0;
      q.sense1   <= 1'b0;
      q.rd_iso   <= 1'b0;
      q.smp      <= 2'h0;
      q.sd_out   <= 8'h00;
      q.sd_oe    <= 1'b0;
      q.ld_reset <= 1'b0;
      q.rewind   <= 1'b0;
      q.ports_en <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sd_out         = q.sd_out;
  assign sd_oe          = q.sd_oe;
  assign cfg_ports_en   = q.ports_en;
  assign card_state     = q.st;
  assign card_handle    = q.handle;
  assign ld_reset       = q.ld_reset;
  assign res_ptr_rewind = q.rewind;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_wait_key: assert property ($rose(rst_n) |-> q.st == CIL_WAIT_KEY && q.handle == CIL_HANDLE_NONE)
    else $error("reset did not leave card waiting for key");

  a_quiet_wait_key: assert property (q.st == CIL_WAIT_KEY && $past(q.st) == CIL_WAIT_KEY |-> !q.sd_oe)
    else $error("bus driven while waiting for key");

  a_key_to_sleep: assert property (q.st == CIL_WAIT_KEY && key_ok |=> q.st == CIL_SLEEP)
    else $error("key seen but card not asleep");

  a_iso_pattern: assert property (q.sd_oe && q.rd_iso |-> q.sd_out == (q.second ? CIL_ISO_SECOND : CIL_ISO_FIRST))
    else $error("wrong isolation pattern driven");

  a_zero_floats: assert property (rd_start && at_rdp && q.st == CIL_ISOLATE && q.addr == CIL_REG_ISOLATE
    && q.handle == CIL_HANDLE_NONE && q.idx < CIL_ID_BITS && !id_bit |=> q.rd_iso && !q.sd_oe)
    else $error("zero bit did not float");

  a_drop_out: assert property (rd_end && q.rd_iso && q.second && !id_bit && q.sense1 && match
    |=> q.st == CIL_SLEEP && q.idx == $past(q.idx))
    else $error("losing card stayed in pass");

  a_bit_advance: assert property (rd_end && q.rd_iso && q.second && (id_bit || !q.sense1 || !match)
    |=> q.idx == $past(q.idx) + 7'h1 && !q.second)
    else $error("identifier bit not advanced");

  a_handle_no_iso: assert property (q.handle != CIL_HANDLE_NONE |-> !q.rd_iso)
    else $error("handled card in isolation");

  a_wake_rewind: assert property (wr_end && at_wdata && q.addr == CIL_REG_WAKE && q.st == CIL_SLEEP
    && q.sd_s == q.handle |=> q.rewind ##1 !q.rewind)
    else $error("wake did not rewind once");

endmodule

// File: dv/cil_rival_card.sv
// rival card on the isa bus answering isolation reads with a one bit
`timescale 1ns/1ps
module cil_rival_card
(
  input  wire logic [11:0] sa,
  input  wire logic        ior_n,
  input  wire logic [11:0] rd_addr,
  input  wire logic        id_one,
  output logic             p_oe,
  output logic      [7:0]  p_dat
);
  logic second_q;

  initial second_q = 1'b0;

  // whole byte driven, only while the read strobe is low
  always_comb
  begin
    p_oe  = !ior_n && sa == rd_addr && id_one;
    p_dat = second_q ? 8'haa : 8'h55;
  end

  // pair phase restarts whenever the bench disarms the card
  always @(posedge ior_n or negedge id_one)
  begin
    if (!id_one)
      second_q <= 1'b0;
    else if (sa == rd_addr)
      second_q <= !second_q;
  end
endmodule

// File: dv/cil_core_test.sv
// self-checking bench of the card isolation front end
`timescale 1ns/1ps
module cil_core_test
  import cil_pkg::*;
;
  localparam logic [11:0] RDP = 12'h0203;
  localparam logic [31:0] VEN = 32'h1234_5678;
  localparam logic [31:0] SER = 32'h0000_0001;
  logic        clk;
  logic        rst_n;
  logic [11:0] sa;
  logic        aen;
  logic        ior_n;
  logic        iow_n;
  logic [7:0]  tb_dat;
  logic [7:0]  sd_in;
  logic [7:0]  sd_out;
  logic        sd_oe;
  logic        cfg_ports_en;
  logic [1:0]  card_state;
  logic [7:0]  card_handle;
  logic        ld_reset;
  logic        res_ptr_rewind;
  logic        rival_one;
  logic        p_oe;
  logic [7:0]  p_dat;
  logic [7:0]  rd_val;
  logic        oe_seen;
  logic        dat_oe;
  int          n_fail;
  int          n_compared;
  int          n_ld;
  int          n_rew;
  int          n_cyc;

  // backplane pull-ups hold undriven lines high
  // write data stays on the bus past the strobe so the synchroniser catches it
  assign sd_in = sd_oe ? sd_out : p_oe ? p_dat : dat_oe ? tb_dat : 8'hff;

  cil_core u_cil_core (.clk(clk), .rst_n(rst_n), .sa(sa), .aen(aen), .ior_n(ior_n),
    .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .cfg_ports_en(cfg_ports_en),
    .card_state(card_state), .card_handle(card_handle), .ld_reset(ld_reset),
    .res_ptr_rewind(res_ptr_rewind));

  cil_rival_card u_cil_rival_card (.sa(sa), .ior_n(ior_n), .rd_addr(RDP), .id_one(rival_one),
    .p_oe(p_oe), .p_dat(p_dat));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // pulses counted here so a one-cycle output is never missed
  always @(posedge clk)
  begin
    n_cyc++;
    if (ld_reset === 1'b1)
      n_ld++;
    if (res_ptr_rewind === 1'b1)
      n_rew++;
    if (n_cyc > 60000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // strobe and address held well past the 3-edge synchroniser
  task automatic io(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    sa <= a;
    tb_dat <= d;
    dat_oe <= wr;
    iow_n <= !wr;
    ior_n <= wr;
    repeat (6) @(posedge clk);
    rd_val = sd_in;
    oe_seen = sd_oe;
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    repeat (6) @(posedge clk);
    dat_oe <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
    io(1'b1, 12'h0279, r);
    io(1'b1, 12'h0a79, d);
  endtask

  task automatic keys(input int n, input int skip);
    logic [7:0] k;
    k = 8'h6a;
    for (int i = 0; i < n; i++)
    begin
      if (i >= skip)
        io(1'b1, 12'h0279, k);
      k = {k[1] ^ k[0], k[7:1]};
    end
  endtask

  // one read pair; spacing cut short since the card needs no settling time
  task automatic pair(output logic one, output logic oe1);
    logic [7:0] r1;
    repeat (20) @(posedge clk);
    io(1'b0, RDP, 8'h00);
    r1 = rd_val;
    oe1 = oe_seen;
    io(1'b0, RDP, 8'h00);
    one = r1 == 8'h55 && rd_val == 8'haa;
  endtask

  function automatic logic [7:0] cks(input logic [63:0] b);
    logic [7:0] c;
    c = 8'h6a;
    for (int i = 0; i < 64; i++)
      c = {c[1] ^ c[0] ^ b[i], c[7:1]};
    return c;
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("state", {6'h00, card_state}, {6'h00, CIL_WAIT_KEY});
    chk("handle", card_handle, 8'h00);
    chk("ports", {7'h00, cfg_ports_en}, 8'h00);
    io(1'b0, RDP, 8'h00);
    chk("drive", {7'h00, oe_seen}, 8'h00);
    io(1'b0, RDP, 8'h00);
    chk("drive", {7'h00, oe_seen}, 8'h00);
  endtask

  task automatic t_key();
    keys(31, 0);
    io(1'b0, 12'h0279, 8'h00);
    keys(32, 31);
    chk("state", {6'h00, card_state}, {6'h00, CIL_WAIT_KEY});
    keys(32, 0);
    chk("state", {6'h00, card_state}, {6'h00, CIL_SLEEP});
    chk("ports", {7'h00, cfg_ports_en}, 8'h01);
  endtask

  task automatic t_iso_alone();
    logic [71:0] exp_id;
    logic [71:0] got;
    logic        g;
    logic        o1;
    exp_id = {cks({SER, VEN}), SER, VEN};
    wr_reg(CIL_REG_SET_RD, 8'h81);
    wr_reg(CIL_REG_WAKE, 8'h00);
    chk("state", {6'h00, card_state}, {6'h00, CIL_ISOLATE});
    chk("rewinds", n_rew[7:0], 8'h01);
    io(1'b1, 12'h0279, CIL_REG_ISOLATE);
    // first pass on a port the card is not at: no pattern, host moves it
    pair(g, o1);
    chk("no pattern", {7'h00, g}, 8'h00);
    wr_reg(CIL_REG_SET_RD, 8'h80);
    io(1'b1, 12'h0279, CIL_REG_ISOLATE);
    for (int i = 0; i < 72; i++)
    begin
      pair(g, o1);
      got[i] = g;
      chk("drive", {7'h00, o1}, {7'h00, exp_id[i]});
      chk("id bit", {7'h00, got[i]}, {7'h00, exp_id[i]});
    end
    chk("checksum", got[71:64], cks(got[63:0]));
    chk("nonzero", {7'h00, got != 72'h0}, 8'h01);
    wr_reg(CIL_REG_HANDLE, 8'h01);
    chk("state", {6'h00, card_state}, {6'h00, CIL_CONFIG});
    chk("handle", card_handle, 8'h01);
  endtask

  task automatic t_commands();
    logic g;
    logic o;
    wr_reg(CIL_REG_CTRL, 8'h02);
    chk("state", {6'h00, card_state}, {6'h00, CIL_WAIT_KEY});
    chk("handle", card_handle, 8'h01);
    keys(32, 0);
    wr_reg(CIL_REG_WAKE, 8'h00);
    chk("state", {6'h00, card_state}, {6'h00, CIL_SLEEP});
    io(1'b1, 12'h0279, CIL_REG_ISOLATE);
    pair(g, o);
    chk("no pattern", {7'h00, g}, 8'h00);
    chk("drive", {7'h00, o}, 8'h00);
    wr_reg(CIL_REG_WAKE, 8'h01);
    chk("state", {6'h00, card_state}, {6'h00, CIL_CONFIG});
    io(1'b1, 12'h0279, CIL_REG_HANDLE);
    io(1'b0, RDP, 8'h00);
    chk("drive", {7'h00, oe_seen}, 8'h01);
    chk("handle read", rd_val, 8'h01);
    wr_reg(CIL_REG_CTRL, 8'h01);
    chk("dev resets", n_ld[7:0], 8'h01);
    wr_reg(CIL_REG_CTRL, 8'h06);
    chk("state", {6'h00, card_state}, {6'h00, CIL_WAIT_KEY});
    chk("handle", card_handle, 8'h00);
  endtask

  // rival drives a one while this card floats on a zero bit
  task automatic t_rival();
    keys(32, 0);
    wr_reg(CIL_REG_SET_RD, 8'h80);
    wr_reg(CIL_REG_WAKE, 8'h00);
    io(1'b1, 12'h0279, CIL_REG_ISOLATE);
    rival_one <= 1'b1;
    io(1'b0, RDP, 8'h00);
    chk("drive", {7'h00, oe_seen}, 8'h00);
    io(1'b0, RDP, 8'h00);
    chk("wire", rd_val, 8'haa);
    chk("state", {6'h00, card_state}, {6'h00, CIL_SLEEP});
    rival_one <= 1'b0;
    io(1'b1, 12'h0279, CIL_REG_HANDLE);
    io(1'b0, RDP, 8'h00);
    chk("drive", {7'h00, oe_seen}, 8'h00);
    wr_reg(CIL_REG_WAKE, 8'h00);
    chk("state", {6'h00, card_state}, {6'h00, CIL_ISOLATE});
    // hardware reset in mid pass
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("state", {6'h00, card_state}, {6'h00, CIL_WAIT_KEY});
    chk("ports", {7'h00, cfg_ports_en}, 8'h00);
  endtask

  // host keeps no other cycles on the bus while keying, except the address-port read that t_key puts in to break a key
  initial
  begin
    rst_n = 1'b0;
    sa = 12'h000;
    aen = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    tb_dat = 8'h00;
    dat_oe = 1'b0;
    rival_one = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_key();
    t_iso_alone();
    t_commands();
    t_rival();
    close_out();
  end
endmodule
